// >>> hw/filter_cal_otp_defines.vh
// register offsets, field positions, reset values and timing for the calibration/fuse status bank
// assumes a 125 MHz clock when the burn time is turned into a cycle count
`ifndef FILTER_CAL_OTP_DEFINES_VH
`define FILTER_CAL_OTP_DEFINES_VH

// register offsets (serial port register index)
`define ADDR_GENERAL_CONFIG 6'h01
`define ADDR_CAL_STROBE 6'h04
`define ADDR_CAL_STATUS 6'h08
`define ADDR_CAL_COUNT 6'h09
`define ADDR_FUSE_VALUES 6'h0A
`define ADDR_FUSE_WRITE_ENABLE 6'h0B
`define ADDR_FUSE_BIT_ADDRESS 6'h0C
`define ADDR_FUSE_WRITE_STROBE 6'h0D
`define ADDR_SELFTEST_ENABLE 6'h0E
`define ADDR_SELFTEST_RESULT 6'h0F

// calibration status fields
`define STAT_FINE_LSB 0
`define STAT_CAL_BUSY_BIT 4
`define STAT_FUSE_BUSY_BIT 5
`define FINE_CODE_MAX 4'hB

// fuse readback fields
`define FUSE_FINE_LSB 0
`define FUSE_COARSE_LO_LSB 4
`define FUSE_GAIN_BIT 7
`define FUSE_BYPASS_BIT 8
`define FUSE_AMP_BIAS_LSB 9
`define FUSE_DRV_BIAS_LSB 11
`define FUSE_PRG_FLAG_BIT 13
`define FUSE_COARSE_MSB_BIT 14
`define FUSE_RESERVED_BIT 15

// self-test result fields
`define SELFTEST_PENDING_BIT 16

// enable bit position in the enable registers
`define ENABLE_BIT 0

// reset values
`define RESET_WORD 24'h000000
`define RESET_CRC 16'h0000
`define RESET_FINE 4'h0

// level forced on general-config bit 0 while the fuse bank is unprogrammed
`define UNPROG_CFG_BIT0 1'b1

// timing
`define CLOCK_PERIOD_PS 8000
`define FUSE_BURN_TIME_NS 1000
`define FUSE_BURN_CYCLES ((`FUSE_BURN_TIME_NS * 1000 + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)

`endif

// >>> hw/filter_cal_otp_status_regs.v
// status, fuse and self-test register bank of the dual low-pass filter control logic
// assumes the serial port front end delivers decoded one-cycle read/write strobes with index and data,
// and that the calibration engine and fuse array report through plain synchronous inputs
//
// Overview of operation
// - status bits [3:0] show calibrated fine code
// - status bits 4/5 flag calibration/fuse burn busy
// - count register returns raw 24-bit calibration counter
// - fuse readback [3:0] holds stored fine code
// - fuse readback holds stored settings copies
// - stored coarse MSB at bit 14, 15 reserved
// - stored settings used only when programmed-flag set
// - unprogrammed flag overrides general config bit 0
// - write to 0Dh burns the addressed fuse when 0Bh enables it and no burn runs
// - self-test result holds 16-bit CRC, resets zero
// - pending flag marks CRC invalid until done
// - write to 04h starts calibration or self-test
// - software fine code used only when forced
`timescale 1ns/1ps
`include "filter_cal_otp_defines.vh"

module filter_cal_otp_status_regs #(
  parameter ADDR_WIDTH = 6,
  parameter DATA_WIDTH = 24,
  parameter FUSE_BURN_CYCLES = `FUSE_BURN_CYCLES
) (
  // clock and reset
  input wire clock_i,
  input wire rstn_i,
  // decoded register access from the serial port
  input wire reg_write_i,
  input wire reg_read_i,
  input wire [ADDR_WIDTH-1:0] reg_addr_i,
  input wire [DATA_WIDTH-1:0] reg_wdata_i,
  output reg [DATA_WIDTH-1:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // lower register fields supplied by the rest of the map
  input wire cfg_bit0_i,
  input wire force_cal_code_i,
  input wire [3:0] sw_fine_code_i,
  input wire [1:0] sw_amp_bias_i,
  input wire [1:0] sw_drv_bias_i,
  input wire sw_gain_select_i,
  input wire sw_bypass_i,
  input wire [3:0] sw_coarse_code_i,
  // calibration engine
  output reg cal_start_o,
  output reg selftest_start_o,
  input wire cal_done_i,
  input wire [3:0] cal_fine_code_i,
  input wire [23:0] cal_count_i,
  input wire selftest_done_i,
  input wire [15:0] selftest_crc_i,
  // fuse array
  input wire [15:0] fuse_bits_i,
  output reg fuse_burn_o,
  output reg [3:0] fuse_burn_index_o,
  // settings in effect
  output reg cfg_bit0_eff_o,
  output reg [3:0] fine_code_eff_o,
  output reg [1:0] amp_bias_eff_o,
  output reg [1:0] drv_bias_eff_o,
  output reg gain_select_eff_o,
  output reg bypass_eff_o,
  output reg [3:0] coarse_code_eff_o
);

  localparam BURN_IDLE = 2'b01;
  localparam BURN_RUN = 2'b10;
  localparam CNT_W = 16;

  reg [3:0] cal_fine_code;
  reg cal_busy;
  reg fuse_burn_active_flag;
  reg [23:0] cal_count;
  reg fuse_program_enable;
  reg [3:0] fuse_bit_address;
  reg selftest_mode_enable;
  reg [15:0] selftest_signature;
  reg selftest_pending_flag;
  reg [1:0] burn_state;
  reg [CNT_W-1:0] burn_count;
  reg [DATA_WIDTH-1:0] next_rdata;

  wire [15:0] fuse_view;
  wire prg_flag;
  wire wr_strobe_cal;
  wire wr_strobe_fuse;
  wire burn_accept;
  wire wr_fuse_enable;
  wire wr_fuse_address;
  wire wr_selftest_enable;
  wire [3:0] stored_fine_code;
  wire [3:0] stored_coarse_code;
  wire stored_gain_select;
  wire stored_bypass;
  wire [1:0] stored_amp_bias;
  wire [1:0] stored_drv_bias;

  function is_write;
    input [ADDR_WIDTH-1:0] addr;
    input [ADDR_WIDTH-1:0] target;
    begin
      is_write = reg_write_i && (addr == target);
    end
  endfunction

  function [3:0] clip_fine_code;
    input [3:0] code;
    begin
      if (code > `FINE_CODE_MAX) begin
        clip_fine_code = `FINE_CODE_MAX;
      end else begin
        clip_fine_code = code;
      end
    end
  endfunction

  // reserved bit 15 never shows a stored value
  assign fuse_view = {1'b0, fuse_bits_i[14:0]};
  assign prg_flag = fuse_bits_i[`FUSE_PRG_FLAG_BIT];
  assign wr_strobe_cal = is_write(reg_addr_i, `ADDR_CAL_STROBE);
  assign wr_strobe_fuse = is_write(reg_addr_i, `ADDR_FUSE_WRITE_STROBE);
  // burn accepted only when enabled and not already burning
  assign burn_accept = wr_strobe_fuse && fuse_program_enable && (burn_state == BURN_IDLE);
  assign wr_fuse_enable = is_write(reg_addr_i, `ADDR_FUSE_WRITE_ENABLE);
  assign wr_fuse_address = is_write(reg_addr_i, `ADDR_FUSE_BIT_ADDRESS);
  assign wr_selftest_enable = is_write(reg_addr_i, `ADDR_SELFTEST_ENABLE);
  // stored settings as laid out in the fuse word
  assign stored_fine_code = fuse_view[`FUSE_FINE_LSB +: 4];
  assign stored_coarse_code = {fuse_view[`FUSE_COARSE_MSB_BIT], fuse_view[`FUSE_COARSE_LO_LSB +: 3]};
  assign stored_gain_select = fuse_view[`FUSE_GAIN_BIT];
  assign stored_bypass = fuse_view[`FUSE_BYPASS_BIT];
  assign stored_amp_bias = fuse_view[`FUSE_AMP_BIAS_LSB +: 2];
  assign stored_drv_bias = fuse_view[`FUSE_DRV_BIAS_LSB +: 2];

  // writable control registers
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fuse_program_enable <= 1'b0;
      fuse_bit_address <= 4'h0;
      selftest_mode_enable <= 1'b0;
    end else begin
      if (wr_fuse_enable) begin
        fuse_program_enable <= reg_wdata_i[`ENABLE_BIT];
      end
      if (wr_fuse_address) begin
        fuse_bit_address <= reg_wdata_i[3:0];
      end
      if (wr_selftest_enable) begin
        selftest_mode_enable <= reg_wdata_i[`ENABLE_BIT];
      end
    end
  end

  // calibration and self-test start, busy and results
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cal_start_o <= 1'b0;
      selftest_start_o <= 1'b0;
      cal_busy <= 1'b0;
      cal_fine_code <= `RESET_FINE;
      cal_count <= `RESET_WORD;
      selftest_signature <= `RESET_CRC;
      selftest_pending_flag <= 1'b0;
    end else begin
      cal_start_o <= wr_strobe_cal && !selftest_mode_enable;
      selftest_start_o <= wr_strobe_cal && selftest_mode_enable;
      if (cal_done_i && !selftest_pending_flag) begin
        cal_fine_code <= clip_fine_code(cal_fine_code_i);
        cal_count <= cal_count_i;
      end
      // a new start wins over a completion in the same cycle
      if (wr_strobe_cal && !selftest_mode_enable) begin
        cal_busy <= 1'b1;
      end else if (cal_done_i) begin
        cal_busy <= 1'b0;
      end
      if (selftest_done_i && selftest_pending_flag) begin
        selftest_signature <= selftest_crc_i;
      end
      if (wr_strobe_cal && selftest_mode_enable) begin
        selftest_pending_flag <= 1'b1;
      end else if (selftest_done_i) begin
        selftest_pending_flag <= 1'b0;
      end
    end
  end

  // fuse burn sequencer
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      burn_state <= BURN_IDLE;
      burn_count <= {CNT_W{1'b0}};
      fuse_burn_o <= 1'b0;
      fuse_burn_index_o <= 4'h0;
      fuse_burn_active_flag <= 1'b0;
    end else begin
      case (burn_state)
        BURN_IDLE: begin
          if (burn_accept) begin
            burn_state <= BURN_RUN;
            burn_count <= FUSE_BURN_CYCLES[CNT_W-1:0] - 1'b1;
            fuse_burn_o <= 1'b1;
            fuse_burn_index_o <= fuse_bit_address;
            fuse_burn_active_flag <= 1'b1;
          end
        end
        BURN_RUN: begin
          if (burn_count == {CNT_W{1'b0}}) begin
            burn_state <= BURN_IDLE;
            fuse_burn_o <= 1'b0;
            fuse_burn_active_flag <= 1'b0;
          end else begin
            burn_count <= burn_count - 1'b1;
          end
        end
        default: begin
          burn_state <= BURN_IDLE;
          fuse_burn_o <= 1'b0;
          fuse_burn_active_flag <= 1'b0;
        end
      endcase
    end
  end

  // settings in effect
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_bit0_eff_o <= `UNPROG_CFG_BIT0;
      fine_code_eff_o <= `RESET_FINE;
      amp_bias_eff_o <= 2'h0;
      drv_bias_eff_o <= 2'h0;
      gain_select_eff_o <= 1'b0;
      bypass_eff_o <= 1'b0;
      coarse_code_eff_o <= 4'h0;
    end else begin
      cfg_bit0_eff_o <= prg_flag ? cfg_bit0_i : `UNPROG_CFG_BIT0;
      if (force_cal_code_i) begin
        fine_code_eff_o <= sw_fine_code_i;
      end else if (prg_flag) begin
        fine_code_eff_o <= stored_fine_code;
      end else begin
        fine_code_eff_o <= cal_fine_code;
      end
      if (prg_flag) begin
        amp_bias_eff_o <= stored_amp_bias;
        drv_bias_eff_o <= stored_drv_bias;
        gain_select_eff_o <= stored_gain_select;
        bypass_eff_o <= stored_bypass;
        coarse_code_eff_o <= stored_coarse_code;
      end else begin
        amp_bias_eff_o <= sw_amp_bias_i;
        drv_bias_eff_o <= sw_drv_bias_i;
        gain_select_eff_o <= sw_gain_select_i;
        bypass_eff_o <= sw_bypass_i;
        coarse_code_eff_o <= sw_coarse_code_i;
      end
    end
  end

  // read multiplexer
  always @* begin
    next_rdata = {DATA_WIDTH{1'b0}};
    case (reg_addr_i)
      `ADDR_CAL_STATUS: begin
        next_rdata[`STAT_FINE_LSB +: 4] = cal_fine_code;
        next_rdata[`STAT_CAL_BUSY_BIT] = cal_busy;
        next_rdata[`STAT_FUSE_BUSY_BIT] = fuse_burn_active_flag;
      end
      `ADDR_CAL_COUNT: begin
        next_rdata[23:0] = cal_count;
      end
      `ADDR_FUSE_VALUES: begin
        next_rdata[15:0] = fuse_view;
      end
      `ADDR_FUSE_WRITE_ENABLE: begin
        next_rdata[`ENABLE_BIT] = fuse_program_enable;
      end
      `ADDR_FUSE_BIT_ADDRESS: begin
        next_rdata[3:0] = fuse_bit_address;
      end
      `ADDR_SELFTEST_ENABLE: begin
        next_rdata[`ENABLE_BIT] = selftest_mode_enable;
      end
      `ADDR_SELFTEST_RESULT: begin
        next_rdata[15:0] = selftest_signature;
        next_rdata[`SELFTEST_PENDING_BIT] = selftest_pending_flag;
      end
      default: begin
        next_rdata = {DATA_WIDTH{1'b0}};
      end
    endcase
  end

  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= {DATA_WIDTH{1'b0}};
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_read_i;
      if (reg_read_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

endmodule

// >>> bench/filter_cal_otp_status_regs_checker.sv
// assertions on the status, fuse and self-test register bank
// assumes it is bound to the bank and sees only its ports
`timescale 1ns/1ps
module filter_cal_otp_status_regs_checker #(
  parameter FUSE_BURN_CYCLES = 3
) (
  // clock and reset
  input wire clock_i,
  input wire rstn_i,
  // register access
  input wire reg_write_i,
  input wire reg_read_i,
  input wire [5:0] reg_addr_i,
  input wire [23:0] reg_rdata_o,
  input wire reg_rvalid_o,
  // engine, fuses and settings
  input wire cfg_bit0_i,
  input wire cal_start_o,
  input wire selftest_start_o,
  input wire [15:0] fuse_bits_i,
  input wire fuse_burn_o,
  input wire [3:0] fuse_burn_index_o,
  input wire cfg_bit0_eff_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  wire cal_strobe = reg_write_i && reg_addr_i == 6'h04;
  wire burn_strobe = reg_write_i && reg_addr_i == 6'h0D;
  wire [14:0] fuse_low = fuse_bits_i[14:0];
  reg [7:0] burn_len;
  // counts the cycles of one burn
  always @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
      burn_len <= 8'h00;
    else
      burn_len <= fuse_burn_o ? burn_len + 8'h01 : 8'h00;
  property p_start; cal_strobe |=> cal_start_o ^ selftest_start_o; endproperty
  a_start: assert property (p_start) else $error("strobe gave no single start");
  property p_burn_len; $fell(fuse_burn_o) |-> burn_len == FUSE_BURN_CYCLES; endproperty
  a_burn_len: assert property (p_burn_len) else $error("burn length wrong");
  property p_burn_cause; $rose(fuse_burn_o) |-> $past(burn_strobe); endproperty
  a_burn_cause: assert property (p_burn_cause) else $error("burn without strobe");
  property p_idx; fuse_burn_o && $past(fuse_burn_o) |-> $stable(fuse_burn_index_o); endproperty
  a_idx: assert property (p_idx) else $error("burn index moved");
  property p_override; !fuse_bits_i[13] |=> cfg_bit0_eff_o; endproperty
  a_override: assert property (p_override) else $error("config bit not overridden");
  property p_prog; fuse_bits_i[13] |=> cfg_bit0_eff_o == $past(cfg_bit0_i); endproperty
  a_prog: assert property (p_prog) else $error("config bit not following");
  property p_fuse_read; reg_read_i && reg_addr_i == 6'h0A |=> reg_rdata_o == {9'h000, $past(fuse_low)}; endproperty
  a_fuse_read: assert property (p_fuse_read) else $error("fuse readback wrong");
  property p_status_read; reg_read_i && reg_addr_i == 6'h08 |=> reg_rvalid_o && reg_rdata_o[23:6] == 18'h00000; endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
  cover property (cal_strobe ##1 cal_start_o);
  cover property (cal_strobe ##1 selftest_start_o);
  cover property ($fell(fuse_burn_o));
endmodule
bind filter_cal_otp_status_regs filter_cal_otp_status_regs_checker #(.FUSE_BURN_CYCLES(FUSE_BURN_CYCLES)) u_checker (
  .clock_i(clock_i), .rstn_i(rstn_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .cfg_bit0_i(cfg_bit0_i),
  .cal_start_o(cal_start_o), .selftest_start_o(selftest_start_o), .fuse_bits_i(fuse_bits_i),
  .fuse_burn_o(fuse_burn_o), .fuse_burn_index_o(fuse_burn_index_o), .cfg_bit0_eff_o(cfg_bit0_eff_o)
);

// >>> bench/far_engine_model.sv
// far-side model: calibration engine and fuse array
// assumes one-cycle start pulses and a burn level from the bank
`timescale 1ns/1ps
module far_engine_model (
  // clock and reset
  input wire clock_i,
  input wire rstn_i,
  // from the bank
  input wire cal_start_i,
  input wire selftest_start_i,
  input wire fuse_burn_i,
  input wire [3:0] fuse_burn_index_i,
  // to the bank
  output reg cal_done_o,
  output reg selftest_done_o,
  output wire [3:0] cal_fine_code_o,
  output wire [23:0] cal_count_o,
  output wire [15:0] selftest_crc_o,
  output reg [15:0] fuse_bits_o
);
  reg [2:0] wait_count;
  reg selftest_run;
  // results mean something only with their done pulse
  assign cal_fine_code_o = cal_done_o ? 4'h7 : 4'h8;
  assign cal_count_o = cal_done_o ? 24'h00ABCD : 24'hFF5432;
  assign selftest_crc_o = selftest_done_o ? 16'h5A3C : 16'hA5C3;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_count <= 3'h0;
      selftest_run <= 1'b0;
      cal_done_o <= 1'b0;
      selftest_done_o <= 1'b0;
      fuse_bits_o <= 16'h0000;
    end else begin
      cal_done_o <= wait_count == 3'h1 && !selftest_run;
      selftest_done_o <= wait_count == 3'h1 && selftest_run;
      if (cal_start_i || selftest_start_i) begin
        wait_count <= 3'h6;
        selftest_run <= selftest_start_i;
      end else if (wait_count != 3'h0)
        wait_count <= wait_count - 3'h1;
      if (fuse_burn_i)
        fuse_bits_o[fuse_burn_index_i] <= 1'b1;
    end
  end
endmodule

// >>> bench/filter_cal_otp_status_regs_bench.sv
// testbench for the status, fuse and self-test register bank
// assumes the far-side model answers starts and burns
`timescale 1ns/1ps
module filter_cal_otp_status_regs_bench;
  reg clock_i = 1'b0, rstn_i = 1'b0, reg_write_i = 1'b0, reg_read_i = 1'b0;
  reg cfg_bit0_i = 1'b0, force_cal_code_i = 1'b0;
  reg [5:0] reg_addr_i = 6'h00;
  reg [23:0] reg_wdata_i = 24'h000000, seen;
  reg [3:0] sw_fine_code_i = 4'h0, sw_coarse_code_i = 4'h6;
  reg [1:0] sw_amp_bias_i = 2'h1, sw_drv_bias_i = 2'h2;
  reg sw_gain_select_i = 1'b1, sw_bypass_i = 1'b1;
  wire [23:0] reg_rdata_o, cal_count_i;
  wire reg_rvalid_o, cal_start_o, selftest_start_o, cal_done_i, selftest_done_i, fuse_burn_o, cfg_bit0_eff_o;
  wire gain_select_eff_o, bypass_eff_o;
  wire [1:0] amp_bias_eff_o, drv_bias_eff_o;
  wire [3:0] cal_fine_code_i, fuse_burn_index_o, fine_code_eff_o, coarse_code_eff_o;
  wire [23:0] eff_word = {14'h0000, amp_bias_eff_o, drv_bias_eff_o, gain_select_eff_o, bypass_eff_o, coarse_code_eff_o};
  wire [15:0] selftest_crc_i, fuse_bits_i;
  integer bad_count = 0, tests_run = 0;
  always #4 clock_i = ~clock_i;
  filter_cal_otp_status_regs #(.FUSE_BURN_CYCLES(3)) u_filter_cal_otp_status_regs (
    .clock_i(clock_i), .rstn_i(rstn_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .cfg_bit0_i(cfg_bit0_i), .force_cal_code_i(force_cal_code_i), .sw_fine_code_i(sw_fine_code_i),
    .sw_amp_bias_i(sw_amp_bias_i), .sw_drv_bias_i(sw_drv_bias_i), .sw_gain_select_i(sw_gain_select_i),
    .sw_bypass_i(sw_bypass_i), .sw_coarse_code_i(sw_coarse_code_i), .cal_start_o(cal_start_o),
    .selftest_start_o(selftest_start_o),
    .cal_done_i(cal_done_i), .cal_fine_code_i(cal_fine_code_i), .cal_count_i(cal_count_i),
    .selftest_done_i(selftest_done_i), .selftest_crc_i(selftest_crc_i), .fuse_bits_i(fuse_bits_i),
    .fuse_burn_o(fuse_burn_o), .fuse_burn_index_o(fuse_burn_index_o), .cfg_bit0_eff_o(cfg_bit0_eff_o),
    .fine_code_eff_o(fine_code_eff_o), .amp_bias_eff_o(amp_bias_eff_o), .drv_bias_eff_o(drv_bias_eff_o),
    .gain_select_eff_o(gain_select_eff_o), .bypass_eff_o(bypass_eff_o), .coarse_code_eff_o(coarse_code_eff_o)
  );
  far_engine_model u_far_engine_model (
    .clock_i(clock_i), .rstn_i(rstn_i), .cal_start_i(cal_start_o), .selftest_start_i(selftest_start_o),
    .fuse_burn_i(fuse_burn_o), .fuse_burn_index_i(fuse_burn_index_o), .cal_done_o(cal_done_i),
    .selftest_done_o(selftest_done_i), .cal_fine_code_o(cal_fine_code_i), .cal_count_o(cal_count_i),
    .selftest_crc_o(selftest_crc_i), .fuse_bits_o(fuse_bits_i)
  );
  task chk(input [95:0] n, input [23:0] e, input [23:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task wr(input [5:0] a, input [23:0] d);
    begin
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_write_i = 1'b1;
      @(posedge clock_i) #1;
      reg_write_i = 1'b0;
      @(posedge clock_i) #1;
    end
  endtask
  task rd(input [5:0] a);
    begin
      reg_addr_i = a;
      reg_read_i = 1'b1;
      @(posedge clock_i) #1;
      reg_read_i = 1'b0;
      seen = reg_rdata_o;
      chk("rvalid", 24'h000001, {23'h000000, reg_rvalid_o});
      @(posedge clock_i) #1;
    end
  endtask
  task rdc(input [5:0] a, input [23:0] e, input [95:0] n);
    begin
      rd(a);
      chk(n, e, seen);
    end
  endtask
  task poll(input [5:0] a, input integer b);
    integer i;
    begin
      rd(a);
      for (i = 0; i < 30 && seen[b] !== 1'b0; i = i + 1)
        rd(a);
      chk("poll_done", 24'h000000, {23'h000000, seen[b]});
    end
  endtask
  task burn(input [3:0] b);
    begin
      wr(6'h0C, {20'h00000, b});
      wr(6'h0D, 24'hFFFFFF);
      poll(6'h08, 5);
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    @(posedge clock_i) #1;
    rdc(6'h0B, 24'h000000, "fuse_en");
    rdc(6'h0C, 24'h000000, "fuse_adr");
    rdc(6'h0E, 24'h000000, "st_en");
    rdc(6'h0F, 24'h000000, "st_res");
    rdc(6'h10, 24'h000000, "unmapped");
    chk("cfg_eff", 24'h000001, {23'h000000, cfg_bit0_eff_o});
    chk("eff_sw", 24'h0001B6, eff_word);
    $display("test reset done");
    wr(6'h04, 24'hFFFFFF);
    rdc(6'h08, 24'h000010, "cal_busy");
    poll(6'h08, 4);
    chk("status", 24'h000007, seen);
    rdc(6'h09, 24'h00ABCD, "count");
    chk("fine_eff", 24'h000007, {20'h00000, fine_code_eff_o});
    $display("test calibration done");
    wr(6'h0E, 24'h000001);
    wr(6'h04, 24'h000000);
    rdc(6'h0F, 24'h010000, "st_pend");
    poll(6'h0F, 16);
    chk("st_crc", 24'h005A3C, seen);
    wr(6'h0E, 24'h000000);
    $display("test self-test done");
    wr(6'h0C, 24'h00000D);
    wr(6'h0D, 24'h000000);
    rdc(6'h08, 24'h000007, "no_burn");
    rdc(6'h0A, 24'h000000, "fuse_blank");
    wr(6'h0B, 24'h000001);
    wr(6'h0D, 24'hFFFFFF);
    rdc(6'h08, 24'h000027, "burn_busy");
    chk("burn_idx", 24'h00000D, {20'h00000, fuse_burn_index_o});
    poll(6'h08, 5);
    rdc(6'h0A, 24'h002000, "fuse_rd");
    chk("cfg_eff", 24'h000000, {23'h000000, cfg_bit0_eff_o});
    chk("fine_fuse", 24'h000000, {20'h00000, fine_code_eff_o});
    burn(4'hE);
    burn(4'hF);
    rdc(6'h0A, 24'h006000, "fuse_rd2");
    chk("eff_fuse", 24'h000008, eff_word);
    force_cal_code_i = 1'b1;
    sw_fine_code_i = 4'h9;
    cfg_bit0_i = 1'b1;
    repeat (2) @(posedge clock_i) #1;
    chk("fine_force", 24'h000009, {20'h00000, fine_code_eff_o});
    chk("cfg_follow", 24'h000001, {23'h000000, cfg_bit0_eff_o});
    $display("test fuse done");
    report_and_stop;
  end
  initial begin
    #20000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule
